// file: verilog/port_mux.sv
// Eight-pin bidirectional port with latch, direction, analog select and pin mux
`timescale 1ns/1ps
module port_mux #(
  parameter int WIDTH = port_mux_pkg::PORT_WIDTH
) (
  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  input wire logic i_clk,
  input wire logic i_reset_n,
  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [port_mux_pkg::ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // ----------------------------------------------------------------
  // Pads
  // ----------------------------------------------------------------
  input wire logic [WIDTH-1:0] i_pin_in,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe_n,
  output logic [WIDTH-1:0] o_analog_enable,
  // ----------------------------------------------------------------
  // Second serial port
  // ----------------------------------------------------------------
  input wire logic i_serial2_spi_clock_out,
  input wire logic i_serial2_spi_clock_en,
  input wire logic i_serial2_i2c_clock_out,
  input wire logic i_serial2_i2c_clock_en,
  output logic o_serial2_clock_in,
  input wire logic i_serial2_i2c_data_out,
  input wire logic i_serial2_i2c_data_en,
  output logic o_serial2_i2c_data_in,
  output logic o_serial2_spi_data_in,
  input wire logic i_serial2_spi_data_out,
  input wire logic i_serial2_spi_data_en,
  output logic o_serial2_slave_select,
  // ----------------------------------------------------------------
  // Capture/compare unit 4
  // ----------------------------------------------------------------
  input wire logic i_capture_compare_unit4_out,
  input wire logic i_capture_compare_unit4_en,
  output logic o_capture_compare_unit4_in,
  // ----------------------------------------------------------------
  // PWM units
  // ----------------------------------------------------------------
  input wire logic i_pwm_unit2_out_b,
  input wire logic i_pwm_unit2_out_b_en,
  input wire logic i_pwm_unit2_out_c,
  input wire logic i_pwm_unit2_out_c_en,
  input wire logic i_pwm_unit2_out_d,
  input wire logic i_pwm_unit2_out_d_en,
  input wire logic i_pwm_unit1_out_b,
  input wire logic i_pwm_unit1_out_b_en,
  output logic o_pwm2b_on_default_pin
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  port_mux_pkg::port_state_t state;
  port_mux_pkg::port_state_t next_state;

  logic [WIDTH-1:0] periph_en;
  logic [WIDTH-1:0] periph_val;
  logic [WIDTH-1:0] digital_in;
  logic access;
  logic mapped;
  logic [7:0] read_value;
  logic arm;
  logic commit;
  logic hit_port;
  logic hit_latch;
  logic hit_dir;
  logic hit_analog;
  logic hit_config;
  logic wr_lane;
  logic wr_port;
  logic wr_latch;
  logic wr_dir;
  logic wr_analog;
  logic wr_config;

  // ----------------------------------------------------------------
  // Peripheral output selection per pin
  // ----------------------------------------------------------------
  // Order within each pin is highest priority first
  always_comb begin
    periph_en = '0;
    periph_val = '0;
    if (i_serial2_spi_clock_en) begin
      periph_en[port_mux_pkg::PIN_SERIAL_CLOCK] = 1'b1;
      periph_val[port_mux_pkg::PIN_SERIAL_CLOCK] = i_serial2_spi_clock_out;
    end else if (i_serial2_i2c_clock_en) begin
      periph_en[port_mux_pkg::PIN_SERIAL_CLOCK] = 1'b1;
      periph_val[port_mux_pkg::PIN_SERIAL_CLOCK] = i_serial2_i2c_clock_out;
    end
    if (i_capture_compare_unit4_en) begin
      periph_en[port_mux_pkg::PIN_CAPTURE_DATA] = 1'b1;
      periph_val[port_mux_pkg::PIN_CAPTURE_DATA] = i_capture_compare_unit4_out;
    end else if (i_serial2_i2c_data_en) begin
      periph_en[port_mux_pkg::PIN_CAPTURE_DATA] = 1'b1;
      periph_val[port_mux_pkg::PIN_CAPTURE_DATA] = i_serial2_i2c_data_out;
    end
    if (i_pwm_unit2_out_b_en && !state.pwm2b_pin_choice) begin
      periph_en[port_mux_pkg::PIN_PWM2_B] = 1'b1;
      periph_val[port_mux_pkg::PIN_PWM2_B] = i_pwm_unit2_out_b;
    end
    if (i_pwm_unit2_out_c_en) begin
      periph_en[port_mux_pkg::PIN_PWM2_C] = 1'b1;
      periph_val[port_mux_pkg::PIN_PWM2_C] = i_pwm_unit2_out_c;
    end
    if (i_pwm_unit2_out_d_en) begin
      periph_en[port_mux_pkg::PIN_PWM2_D] = 1'b1;
      periph_val[port_mux_pkg::PIN_PWM2_D] = i_pwm_unit2_out_d;
    end else if (i_serial2_spi_data_en) begin
      periph_en[port_mux_pkg::PIN_PWM2_D] = 1'b1;
      periph_val[port_mux_pkg::PIN_PWM2_D] = i_serial2_spi_data_out;
    end
    if (i_pwm_unit1_out_b_en) begin
      periph_en[port_mux_pkg::PIN_PWM1_B] = 1'b1;
      periph_val[port_mux_pkg::PIN_PWM1_B] = i_pwm_unit1_out_b;
    end
  end

  // ----------------------------------------------------------------
  // Pad drivers and input paths
  // ----------------------------------------------------------------
  // Driver follows direction only; analog select never gates it
  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    always_comb begin
      o_pin_oe_n[g] = state.pin_direction_bits[g];
      if (periph_en[g]) begin
        o_pin_out[g] = periph_val[g];
      end else begin
        o_pin_out[g] = state.output_latch_reg[g];
      end
      o_analog_enable[g] = state.analog_select_bits[g];
      digital_in[g] = i_pin_in[g] & ~state.analog_select_bits[g];
    end
  end

  // Inputs are taken regardless of direction so clock and I2C lines can sense the wire
  assign o_serial2_clock_in = digital_in[port_mux_pkg::PIN_SERIAL_CLOCK];
  assign o_capture_compare_unit4_in = digital_in[port_mux_pkg::PIN_CAPTURE_DATA];
  assign o_serial2_spi_data_in = digital_in[port_mux_pkg::PIN_CAPTURE_DATA];
  assign o_serial2_i2c_data_in = digital_in[port_mux_pkg::PIN_CAPTURE_DATA];
  assign o_serial2_slave_select = digital_in[port_mux_pkg::PIN_PWM2_C];
  assign o_pwm2b_on_default_pin = state.pwm2b_pin_choice;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  assign access = i_psel && i_penable;

  always_comb begin
    mapped = 1'b1;
    read_value = 8'h00;
    unique case (i_paddr)
      port_mux_pkg::FOURTH_PORT_PINS_OFFSET: read_value = digital_in;
      port_mux_pkg::OUTPUT_LATCH_REG_OFFSET: read_value = state.output_latch_reg;
      port_mux_pkg::PIN_DIRECTION_BITS_OFFSET: read_value = state.pin_direction_bits;
      port_mux_pkg::ANALOG_SELECT_BITS_OFFSET: read_value = state.analog_select_bits;
      port_mux_pkg::DEVICE_CONFIG_PIN_OPTIONS_OFFSET: begin
        read_value[port_mux_pkg::PWM2B_PIN_CHOICE_BIT] = state.pwm2b_pin_choice;
      end
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Address decode and write strobes
  // ----------------------------------------------------------------
  // First access edge arms the answer, second one commits it
  assign arm = access && !state.ready;
  assign commit = access && state.ready;
  assign hit_port = (i_paddr == port_mux_pkg::FOURTH_PORT_PINS_OFFSET);
  assign hit_latch = (i_paddr == port_mux_pkg::OUTPUT_LATCH_REG_OFFSET);
  assign hit_dir = (i_paddr == port_mux_pkg::PIN_DIRECTION_BITS_OFFSET);
  assign hit_analog = (i_paddr == port_mux_pkg::ANALOG_SELECT_BITS_OFFSET);
  assign hit_config = (i_paddr == port_mux_pkg::DEVICE_CONFIG_PIN_OPTIONS_OFFSET);
  // Every register sits in byte lane 0, so only that strobe gates a write
  assign wr_lane = i_pwrite && i_pstrb[0];
  assign wr_port = commit && wr_lane && hit_port;
  assign wr_latch = commit && wr_lane && hit_latch;
  assign wr_dir = commit && wr_lane && hit_dir;
  assign wr_analog = commit && wr_lane && hit_analog;
  assign wr_config = commit && wr_lane && hit_config;

  // One wait state: answer is prepared from flip-flops, write lands with pready
  always_comb begin
    next_state = state;
    if (arm) begin
      next_state.ready = 1'b1;
      next_state.slverr = !mapped;
      next_state.rdata = i_pwrite ? 8'h00 : read_value;
    end
    if (commit) begin
      next_state.ready = 1'b0;
      next_state.slverr = 1'b0;
    end
    // Port and latch addresses write one latch, so a write to either sets it; a port read returns the pins
    if (wr_port || wr_latch) begin
      next_state.output_latch_reg = i_pwdata[7:0];
    end
    if (wr_dir) begin
      next_state.pin_direction_bits = i_pwdata[7:0];
    end
    if (wr_analog) begin
      next_state.analog_select_bits = i_pwdata[7:0];
    end
    if (wr_config) begin
      next_state.pwm2b_pin_choice = i_pwdata[port_mux_pkg::PWM2B_PIN_CHOICE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.output_latch_reg <= port_mux_pkg::OUTPUT_LATCH_RESET;
      state.pin_direction_bits <= port_mux_pkg::PIN_DIRECTION_RESET;
      state.analog_select_bits <= port_mux_pkg::ANALOG_SELECT_RESET;
      state.pwm2b_pin_choice <= port_mux_pkg::PWM2B_PIN_CHOICE_RESET;
      state.ready <= 1'b0;
      state.slverr <= 1'b0;
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign o_pready = state.ready;
  assign o_pslverr = state.ready & state.slverr;
  assign o_prdata = {24'h000000, state.rdata};

endmodule : port_mux

// file: common/port_mux_pkg.sv
// Constants and state type shared by the eight-pin port with pin mux
package port_mux_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] FOURTH_PORT_PINS_OFFSET = 12'h000;
  localparam logic [11:0] OUTPUT_LATCH_REG_OFFSET = 12'h004;
  localparam logic [11:0] PIN_DIRECTION_BITS_OFFSET = 12'h008;
  localparam logic [11:0] ANALOG_SELECT_BITS_OFFSET = 12'h00C;
  localparam logic [11:0] DEVICE_CONFIG_PIN_OPTIONS_OFFSET = 12'h010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PWM2B_PIN_CHOICE_BIT = 5;
  localparam int PIN_SERIAL_CLOCK = 0;
  localparam int PIN_CAPTURE_DATA = 1;
  localparam int PIN_PWM2_B = 2;
  localparam int PIN_PWM2_C = 3;
  localparam int PIN_PWM2_D = 4;
  localparam int PIN_PWM1_B = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] ANALOG_SELECT_RESET = 8'hFF;
  localparam logic PWM2B_PIN_CHOICE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] output_latch_reg;
    logic [7:0] pin_direction_bits;
    logic [7:0] analog_select_bits;
    logic pwm2b_pin_choice;
    logic ready;
    logic slverr;
    logic [7:0] rdata;
  } port_state_t;
endpackage : port_mux_pkg

// file: testbench/port_mux_assertions.sv
// Concurrent checks on the port mux pins and register bus
`timescale 1ns/1ps
module port_mux_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe_n,
  input wire logic [7:0] o_analog_enable,
  input wire logic o_serial2_clock_in,
  input wire logic i_serial2_spi_clock_out,
  input wire logic i_serial2_spi_clock_en,
  input wire logic i_pwm_unit1_out_b,
  input wire logic i_pwm_unit1_out_b_en
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_arm;
    $rose(i_psel && i_penable);
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  sequence s_wr(logic [11:0] a);
    i_psel && i_penable && i_pwrite && o_pready && i_pstrb[0] && i_paddr == a;
  endsequence
  property p_wait;
    s_arm |=> s_answer;
  endproperty
  property p_dir;
    s_wr(12'h008) |=> o_pin_oe_n == $past(i_pwdata[7:0]);
  endproperty
  property p_latch(logic [11:0] a);
    s_wr(a) |=> o_pin_out[7:6] == $past(i_pwdata[7:6]);
  endproperty
  property p_pin0;
    i_serial2_spi_clock_en |-> o_pin_out[0] == i_serial2_spi_clock_out;
  endproperty
  property p_pin5;
    i_pwm_unit1_out_b_en |-> o_pin_out[5] == i_pwm_unit1_out_b;
  endproperty
  property p_ain;
    o_serial2_clock_in == (i_pin_in[0] && !o_analog_enable[0]);
  endproperty
  property p_reset;
    $rose(i_reset_n) |-> o_pin_oe_n == 8'hFF && o_analog_enable == 8'hFF;
  endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  a_dir: assert property (p_dir) else $error("direction not taken");
  a_latch: assert property (p_latch(12'h004)) else $error("latch write lost");
  a_port_wr: assert property (p_latch(12'h000)) else $error("port write lost");
  a_pin0: assert property (p_pin0) else $error("pin 0 clock not driven");
  a_pin5: assert property (p_pin5) else $error("pin 5 pwm not driven");
  a_ain: assert property (p_ain) else $error("digital input not gated");
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : port_mux_assertions

bind port_mux port_mux_assertions port_mux_assertions_i (.*);

// file: testbench/pad_board_model.sv
// Board side of the pads: port driver, board drivers and weak pull-ups
`timescale 1ns/1ps
module pad_board_model (
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe_n,
  input wire logic [7:0] i_board_level,
  input wire logic [7:0] i_board_drive,
  output logic [7:0] o_pad
);
  // Released pads pull high, so a stale level is never read back
  assign o_pad = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & (~i_board_drive | i_board_level));
endmodule : pad_board_model

// file: testbench/port_mux_tb_top.sv
// Self-checking bench for the eight-pin port with pin mux
`timescale 1ns/1ps
module port_mux_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [17:0] pr = 18'h00000;
  logic [7:0] pin_out, oe_n, aen, pad, blvl = 8'hC0, bdrv = 8'hF0;
  int n_mismatch = 0, n_tests = 0;
  logic clk_in, i2c_in, sdi, ccp_in, ss, dflt;
  always #5 clk = ~clk;
  port_mux port_mux_i (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin_in(pad), .o_pin_out(pin_out),
    .o_pin_oe_n(oe_n), .o_analog_enable(aen), .i_serial2_spi_clock_out(pr[0]),
    .i_serial2_spi_clock_en(pr[1]), .i_serial2_i2c_clock_out(pr[2]),
    .i_serial2_i2c_clock_en(pr[3]), .o_serial2_clock_in(clk_in),
    .i_serial2_i2c_data_out(pr[4]), .i_serial2_i2c_data_en(pr[5]),
    .o_serial2_i2c_data_in(i2c_in), .o_serial2_spi_data_in(sdi),
    .i_serial2_spi_data_out(pr[6]), .i_serial2_spi_data_en(pr[7]), .o_serial2_slave_select(ss),
    .i_capture_compare_unit4_out(pr[8]), .i_capture_compare_unit4_en(pr[9]),
    .o_capture_compare_unit4_in(ccp_in), .i_pwm_unit2_out_b(pr[10]),
    .i_pwm_unit2_out_b_en(pr[11]),
    .i_pwm_unit2_out_c(pr[12]), .i_pwm_unit2_out_c_en(pr[13]), .i_pwm_unit2_out_d(pr[14]),
    .i_pwm_unit2_out_d_en(pr[15]), .i_pwm_unit1_out_b(pr[16]), .i_pwm_unit1_out_b_en(pr[17]),
    .o_pwm2b_on_default_pin(dflt));
  pad_board_model pad_board_model_i (.i_pin_out(pin_out), .i_pin_oe_n(oe_n),
    .i_board_level(blvl), .i_board_drive(bdrv), .o_pad(pad));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No cycle limit here; only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_data, e);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(12'h008, 32'hFF);
    rd(12'h00C, 32'hFF);
    rd(12'h010, 32'h20);
    chk({24'h0, oe_n}, 32'hFF);
    chk({24'h0, aen}, 32'hFF);
    chk({31'h0, dflt}, 32'h1);
  endtask : t_reset
  task automatic t_dir_latch();
    apb(1'b1, 12'h004, 32'h5A);
    apb(1'b1, 12'h008, 32'hF0);
    apb(1'b1, 12'h00C, 32'h0F);
    @(negedge clk);
    chk({24'h0, oe_n}, 32'hF0);
    chk({24'h0, pad}, 32'hCA);
    rd(12'h004, 32'h5A);
    rd(12'h000, 32'hC0);
    apb(1'b1, 12'h000, 32'h00);
    rd(12'h004, 32'h00);
  endtask : t_dir_latch
  task automatic t_mux();
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h00C, 32'hFF);
    apb(1'b1, 12'h004, 32'hFF);
    @(posedge clk);
    pr <= 18'h2AAFE;
    @(negedge clk);
    chk({24'h0, pin_out}, 32'hC4);
    apb(1'b1, 12'h010, 32'h00);
    @(negedge clk);
    chk({24'h0, pin_out}, 32'hC0);
    chk({31'h0, dflt}, 32'h0);
    @(posedge clk);
    pr <= 18'h000A8;
    @(negedge clk);
    chk({24'h0, pin_out}, 32'hEC);
  endtask : t_mux
  task automatic t_inputs();
    apb(1'b1, 12'h008, 32'hFF);
    apb(1'b1, 12'h00C, 32'h00);
    @(posedge clk);
    pr <= 18'h00000;
    blvl <= 8'h0A;
    bdrv <= 8'hFF;
    @(negedge clk);
    chk({27'h0, ss, i2c_in, sdi, ccp_in, clk_in}, 32'h1E);
    @(posedge clk);
    blvl <= 8'h05;
    @(negedge clk);
    chk({27'h0, ss, i2c_in, sdi, ccp_in, clk_in}, 32'h01);
    rd(12'h000, 32'h05);
    apb(1'b1, 12'h00C, 32'h0F);
    @(negedge clk);
    chk({27'h0, ss, i2c_in, sdi, ccp_in, clk_in}, 32'h00);
    rd(12'h000, 32'h00);
  endtask : t_inputs
  task automatic t_unmapped();
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd_data, 32'h0);
    apb(1'b1, 12'h020, 32'h33);
    rd(12'h004, 32'hFF);
  endtask : t_unmapped
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_dir_latch();
    t_mux();
    t_inputs();
    t_unmapped();
    end_of_test();
  end
  // Whole run is about a hundred cycles; this is ample margin
  initial begin
    #20000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog timeout", $time);
    end_of_test();
  end
endmodule : port_mux_tb_top
